// file: src/drc_pkg.sv
/*
  Constants, register map and carrier types for the DRAM refresh, SDRAM
  and check-code control block. Assumes a single 250 MHz clock domain.
*/
package drc_pkg;

  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;

  // Register offsets.
  localparam logic [7:0] OFS_REFRESH_INTERVAL = 8'h6A;
  localparam logic [7:0] OFS_REFRESH_STYLE    = 8'h6B;
  localparam logic [7:0] OFS_SYNC_DRAM        = 8'h6C;
  localparam logic [7:0] OFS_PIN_DRIVE        = 8'h6D;
  localparam logic [7:0] OFS_CHECK_CTRL       = 8'h6E;
  localparam logic [7:0] OFS_CHECK_STATUS     = 8'h6F;

  localparam logic [7:0] RST_ZERO = 8'h00;

  // Writable bit masks; everything else reads zero.
  localparam logic [7:0] MSK_REFRESH_STYLE = 8'hC0;
  localparam logic [7:0] MSK_SYNC_DRAM     = 8'hEF;
  localparam logic [7:0] MSK_PIN_DRIVE     = 8'hFF;
  localparam logic [7:0] MSK_CHECK_CTRL    = 8'hBF;

  // Field positions.
  localparam int unsigned BIT_CBR_REFRESH   = 7;
  localparam int unsigned BIT_BURST_REFRESH = 6;
  localparam int unsigned BIT_DEPTH         = 7;
  localparam int unsigned BIT_BURST_WRITE   = 6;
  localparam int unsigned BIT_INTERLEAVE    = 5;
  localparam int unsigned BIT_CAS_LAT       = 3;
  localparam int unsigned BIT_BANK_TEST     = 7;
  localparam int unsigned BIT_PIN_FUNC      = 5;
  localparam int unsigned BIT_FORCE_SMM     = 4;
  localparam int unsigned BIT_CHECK_MODE    = 7;
  localparam int unsigned BIT_SERR_MULTI    = 5;
  localparam int unsigned BIT_SERR_SINGLE   = 4;
  localparam int unsigned BIT_READ_EXTRA    = 3;
  localparam int unsigned BIT_UNCORR_FLAG   = 7;
  localparam int unsigned BIT_CORR_FLAG     = 3;

  // Refresh timing.
  localparam int unsigned TICK_CLOCKS       = 16;
  localparam int unsigned ROWS_SINGLE       = 1;
  localparam int unsigned ROWS_BURST        = 4;
  localparam int unsigned STAGGER_CLOCKS    = 2;
  localparam logic [2:0]  BANK_COUNT        = 3'h6;
  localparam logic [2:0]  BANK_LAST_CODE    = 3'h5;

  // Read timing in clocks.
  localparam logic [1:0] CAS_LAT_SHORT = 2'h2;
  localparam logic [1:0] CAS_LAT_LONG  = 2'h3;
  localparam int unsigned LEADOFF      = 8;
  localparam int unsigned LINE_GAP     = 3;

  typedef enum logic [2:0] {
    DRC_OP_NORMAL    = 3'h0,
    DRC_OP_NOP       = 3'h1,
    DRC_OP_PRECHARGE = 3'h2,
    DRC_OP_COMMAND   = 3'h3,
    DRC_OP_CBR       = 3'h4
  } drc_op_mode_t;

  typedef enum logic [1:0] {
    DRC_CMD_ACCESS,
    DRC_CMD_NOP,
    DRC_CMD_PRECHARGE_ALL,
    DRC_CMD_ADDRESS
  } drc_cmd_kind_t;

  // Register port request.
  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } drc_reg_req_t;

  // Check-code result from the data path.
  typedef struct packed {
    logic       single_err;
    logic       multi_err;
    logic [2:0] bank_code;
  } drc_check_evt_t;

  // Controls sent to the sequencer.
  typedef struct packed {
    logic          cbr_refresh;
    logic          burst_write;
    logic          interleave;
    logic          four_bank;
    logic [1:0]    cas_latency;
    drc_cmd_kind_t cmd_kind;
    logic          pin_as_address;
    logic          smm_active;
    logic          check_ecc;
    logic [2:0]    ecc_pair_en;
    logic          read_extra;
    logic [3:0]    line_gap;
  } drc_ctrl_t;

endpackage

// file: src/drc_top.sv
/*
  DRAM refresh, SDRAM mode and check-code control registers with refresh
  request generation and error status capture.
  Assumes one clock, a register port with one-cycle strobes, and a data
  path that reports check-code results and refresh completion.
*/
// Our own choice: the plain strobed port.
`timescale 1ns/1ps
module drc_top
  import drc_pkg::*;
#(
  parameter int unsigned TICK = TICK_CLOCKS
)(
  input  wire logic           sys_clk_i,        // 250 MHz clock
  input  wire logic           resetn_i,         // Async reset, low
  input  wire drc_reg_req_t   reg_req_i,        // Register request
  output logic [DATA_W-1:0]   reg_rdata_o,      // Read data, next cycle
  input  wire logic           smm_active_input_i, // SMM active pin
  input  wire drc_check_evt_t check_evt_i,      // Check result
  input  wire logic [5:0]     bank_populated_i, // Populated banks
  input  wire logic           refresh_done_i,   // Sequencer took refresh
  output logic                refresh_req_o,    // Refresh request level
  output logic [2:0]          refresh_rows_o,   // Rows per request
  output logic [5:0]          refresh_stagger_o, // Staggered strobes
  output drc_ctrl_t           ctrl_o,           // Sequencer controls
  output logic                serr_o            // System error pulse
);

  ////////////////////////////////////////////////////////////////////////
  logic [7:0] interval_q;
  logic [7:0] style_q;
  logic [7:0] sync_q;
  logic [7:0] drive_q;
  logic [7:0] check_ctrl_q;
  logic       uncorr_flag_q;
  logic [2:0] uncorr_bank_q;
  logic       corr_flag_q;
  logic [2:0] corr_bank_q;
  logic       wr_status;
  logic       pair_on;
  logic       multi_evt;
  logic       single_evt;

  assign wr_status = reg_req_i.wr && reg_req_i.addr == OFS_CHECK_STATUS;

  // Configuration registers; reserved bits are masked at write time.
  always_ff @(posedge sys_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      interval_q   <= RST_ZERO;
      style_q      <= RST_ZERO;
      sync_q       <= RST_ZERO;
      drive_q      <= RST_ZERO;
      check_ctrl_q <= RST_ZERO;
    end
    else if (reg_req_i.wr)
    begin
      unique case (reg_req_i.addr)
        OFS_REFRESH_INTERVAL: interval_q <= reg_req_i.wdata;
        OFS_REFRESH_STYLE:
          style_q <= reg_req_i.wdata & MSK_REFRESH_STYLE;
        OFS_SYNC_DRAM:
          sync_q <= reg_req_i.wdata & MSK_SYNC_DRAM;
        OFS_PIN_DRIVE:   drive_q <= reg_req_i.wdata & MSK_PIN_DRIVE;
        OFS_CHECK_CTRL:
          check_ctrl_q <= reg_req_i.wdata & MSK_CHECK_CTRL;
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Errors count only in ECC mode and in a bank pair whose enable is set.
  // Bank codes past the last bank are ignored as they name no bank.
  assign pair_on = check_evt_i.bank_code <= BANK_LAST_CODE &&
                   check_ctrl_q[check_evt_i.bank_code[2:1]];
  assign multi_evt  = check_ctrl_q[BIT_CHECK_MODE] && pair_on &&
                      check_evt_i.multi_err;
  assign single_evt = check_ctrl_q[BIT_CHECK_MODE] && pair_on &&
                      check_evt_i.single_err && !check_evt_i.multi_err;

  // A new error wins over a clear in the same cycle so it is never lost.
  always_ff @(posedge sys_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      uncorr_flag_q <= 1'b0;
      uncorr_bank_q <= 3'h0;
    end
    else if (multi_evt)
    begin
      uncorr_flag_q <= 1'b1;
      uncorr_bank_q <= check_evt_i.bank_code;
    end
    else if (wr_status)
    begin
      if (reg_req_i.wdata[BIT_UNCORR_FLAG])
        uncorr_flag_q <= 1'b0;
      uncorr_bank_q <= uncorr_bank_q & ~reg_req_i.wdata[6:4];
    end
  end

  // Correction happens in the data path; nothing is written back.
  always_ff @(posedge sys_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      corr_flag_q <= 1'b0;
      corr_bank_q <= 3'h0;
    end
    else if (single_evt)
    begin
      corr_flag_q <= 1'b1;
      corr_bank_q <= check_evt_i.bank_code;
    end
    else if (wr_status)
    begin
      if (reg_req_i.wdata[BIT_CORR_FLAG])
        corr_flag_q <= 1'b0;
      corr_bank_q <= corr_bank_q & ~reg_req_i.wdata[2:0];
    end
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      serr_o <= 1'b0;
    else
      serr_o <= (multi_evt && check_ctrl_q[BIT_SERR_MULTI]) ||
                (single_evt && check_ctrl_q[BIT_SERR_SINGLE]);
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge sys_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      reg_rdata_o <= RST_ZERO;
    else if (reg_req_i.rd)
    begin
      unique case (reg_req_i.addr)
        OFS_REFRESH_INTERVAL: reg_rdata_o <= interval_q;
        OFS_REFRESH_STYLE:    reg_rdata_o <= style_q;
        OFS_SYNC_DRAM:        reg_rdata_o <= sync_q;
        OFS_PIN_DRIVE:        reg_rdata_o <= drive_q;
        OFS_CHECK_CTRL:       reg_rdata_o <= check_ctrl_q;
        OFS_CHECK_STATUS:
          reg_rdata_o <= {uncorr_flag_q, uncorr_bank_q,
                          corr_flag_q, corr_bank_q};
        default:              reg_rdata_o <= RST_ZERO;
      endcase
    end
    else
      reg_rdata_o <= RST_ZERO;
  end

  ////////////////////////////////////////////////////////////////////////
  // Refresh timing: a prescaler makes ticks, the interval counter counts
  // ticks. Burst mode stretches the interval four times and asks for
  // four rows, keeping the same average row rate.
  logic [4:0]  pre_q;
  logic [9:0]  intv_q;
  logic        tick;
  logic [9:0]  reload;
  logic [1:0]  stg_q;
  logic [2:0]  stg_bank_q;

  assign tick   = pre_q == 5'(TICK - 1);
  assign reload = style_q[BIT_BURST_REFRESH] ?
                  {interval_q, 2'b00} : {2'b00, interval_q};

  always_ff @(posedge sys_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      pre_q <= 5'h0;
    else if (interval_q == RST_ZERO || tick)
      pre_q <= 5'h0;
    else
      pre_q <= pre_q + 5'h1;
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      intv_q        <= 10'h0;
      refresh_req_o <= 1'b0;
    end
    else if (interval_q == RST_ZERO)
    begin
      intv_q        <= 10'h0;
      refresh_req_o <= 1'b0;
    end
    else
    begin
      if (tick)
      begin
        if (intv_q <= 10'h1)
          intv_q <= reload;
        else
          intv_q <= intv_q - 10'h1;
      end
      // Expiry raises the request; an expiry wins over done in the same cycle.
      if (tick && intv_q <= 10'h1)
        refresh_req_o <= 1'b1;
      else if (refresh_done_i)
        refresh_req_o <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      refresh_rows_o <= 3'h0;
    else
      refresh_rows_o <= style_q[BIT_BURST_REFRESH] ?
                        3'(ROWS_BURST) : 3'(ROWS_SINGLE);
  end

  // Staggered strobes: one populated bank at a time, spacing set so that
  // supply surges from all banks never coincide.
  always_ff @(posedge sys_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      stg_q             <= 2'h0;
      stg_bank_q        <= 3'h0;
      refresh_stagger_o <= 6'h0;
    end
    else if (!refresh_req_o)
    begin
      stg_q             <= 2'h0;
      stg_bank_q        <= 3'h0;
      refresh_stagger_o <= 6'h0;
    end
    else
    begin
      stg_q <= (stg_q == 2'(STAGGER_CLOCKS - 1)) ? 2'h0 : stg_q + 2'h1;
      if (stg_q == 2'(STAGGER_CLOCKS - 1) && stg_bank_q < BANK_COUNT)
        stg_bank_q <= stg_bank_q + 3'h1;
      if (stg_bank_q < BANK_COUNT)
        refresh_stagger_o <= refresh_stagger_o |
          (bank_populated_i & (6'h1 << stg_bank_q));
    end
  end

  ////////////////////////////////////////////////////////////////////////
  drc_cmd_kind_t cmd_kind;

  always_comb
  begin
    unique case (sync_q[2:0])
      DRC_OP_NOP:       cmd_kind = DRC_CMD_NOP;
      DRC_OP_PRECHARGE: cmd_kind = DRC_CMD_PRECHARGE_ALL;
      DRC_OP_COMMAND:   cmd_kind = DRC_CMD_ADDRESS;
      default:          cmd_kind = DRC_CMD_ACCESS;
    endcase
  end

  // The bank decode test bit is stored only; it steers nothing here.
  always_ff @(posedge sys_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      ctrl_o <= '0;
    else
    begin
      ctrl_o.cbr_refresh    <= style_q[BIT_CBR_REFRESH] ||
                               sync_q[2:0] == DRC_OP_CBR;
      ctrl_o.burst_write    <= sync_q[BIT_BURST_WRITE];
      ctrl_o.interleave     <= sync_q[BIT_INTERLEAVE];
      ctrl_o.four_bank      <= sync_q[BIT_INTERLEAVE] &&
                               sync_q[BIT_DEPTH];
      ctrl_o.cas_latency    <= sync_q[BIT_CAS_LAT] ?
                               CAS_LAT_LONG : CAS_LAT_SHORT;
      ctrl_o.cmd_kind       <= cmd_kind;
      ctrl_o.pin_as_address <= drive_q[BIT_PIN_FUNC];
      ctrl_o.smm_active     <= drive_q[BIT_FORCE_SMM] ||
                               smm_active_input_i;
      ctrl_o.check_ecc      <= check_ctrl_q[BIT_CHECK_MODE];
      ctrl_o.ecc_pair_en    <= check_ctrl_q[2:0];
      ctrl_o.read_extra     <= check_ctrl_q[BIT_READ_EXTRA];
      ctrl_o.line_gap       <= sync_q[BIT_INTERLEAVE] ?
                               4'h1 : 4'(LINE_GAP);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  AST_ZERO_NO_REFRESH: assert property (@(posedge sys_clk_i)
    disable iff (!resetn_i)
    interval_q == RST_ZERO |=> !refresh_req_o)
    else $error("Refresh requested with zero interval.");

  AST_UNCORR_SET: assert property (@(posedge sys_clk_i)
    disable iff (!resetn_i)
    multi_evt |=> uncorr_flag_q &&
                  uncorr_bank_q == $past(check_evt_i.bank_code))
    else $error("Uncorrectable error not captured.");

  AST_CORR_CLEAR: assert property (@(posedge sys_clk_i)
    disable iff (!resetn_i)
    wr_status && reg_req_i.wdata[BIT_CORR_FLAG] && !single_evt
    |=> !corr_flag_q)
    else $error("Corrected flag not cleared by write one.");

  AST_CORR_BANK_CLR: assert property (@(posedge sys_clk_i)
    disable iff (!resetn_i)
    wr_status && reg_req_i.wdata[2:0] == 3'h7 && !single_evt
    |=> corr_bank_q == 3'h0)
    else $error("Corrected bank field not cleared.");

  AST_SERR_GATE: assert property (@(posedge sys_clk_i)
    disable iff (!resetn_i)
    serr_o |-> $past(check_ctrl_q[BIT_SERR_MULTI] ||
                     check_ctrl_q[BIT_SERR_SINGLE]))
    else $error("System error without enable.");

  AST_SMM_FORCE: assert property (@(posedge sys_clk_i)
    disable iff (!resetn_i)
    drive_q[BIT_FORCE_SMM] |=> ctrl_o.smm_active)
    else $error("Forced SMM not reflected.");

  // The first edge after reset still shows the reset value of the
  // controls, so the comparison starts one edge later.
  AST_CAS_LAT: assert property (@(posedge sys_clk_i)
    disable iff (!resetn_i)
    $past(resetn_i) |-> ctrl_o.cas_latency ==
      ($past(sync_q[BIT_CAS_LAT]) ? CAS_LAT_LONG : CAS_LAT_SHORT))
    else $error("Wrong column latency.");

  AST_RESERVED_ZERO: assert property (@(posedge sys_clk_i)
    disable iff (!resetn_i)
    reg_req_i.rd && reg_req_i.addr == OFS_REFRESH_STYLE
    |=> reg_rdata_o[5:0] == 6'h0)
    else $error("Reserved bits read nonzero.");

  // Spacing is judged against the tick parameter, so a shortened tick in
  // simulation is held to the same rule as the real one.
  localparam int TICK_SPAN = TICK;

  AST_TICK_SPACING: assert property (@(posedge sys_clk_i)
    disable iff (!resetn_i)
    tick && interval_q != RST_ZERO
    |-> ##TICK_SPAN (tick || interval_q == RST_ZERO))
    else $error("Refresh tick spacing differs from the tick length.");

  AST_REFRESH_RAISE: assert property (@(posedge sys_clk_i)
    disable iff (!resetn_i)
    tick && intv_q <= 10'h1 && interval_q != RST_ZERO |=> refresh_req_o)
    else $error("Interval expiry raised no refresh request.");

  AST_SERR_MULTI: assert property (@(posedge sys_clk_i)
    disable iff (!resetn_i)
    multi_evt && check_ctrl_q[BIT_SERR_MULTI] |=> serr_o)
    else $error("Enabled uncorrectable error raised no system error.");

  COV_REFRESH: cover property (@(posedge sys_clk_i) $rose(refresh_req_o));
  COV_UNCORR:  cover property (@(posedge sys_clk_i) multi_evt);
  COV_CORR:    cover property (@(posedge sys_clk_i) single_evt ##1 serr_o);
  COV_BURST:   cover property (@(posedge sys_clk_i)
    $rose(refresh_req_o) && refresh_rows_o == 3'(ROWS_BURST));

endmodule

// file: verification/drc_seq_model.sv
/*
  Behavioural model of the DRAM sequencer that serves refresh requests.
  Assumes the block's level refresh request and a one-cycle accept pulse.
*/
`timescale 1ns/1ps
module drc_seq_model (
  input  wire logic       clk_i,   // Sequencer clock
  input  wire logic       rstn_i,  // Async reset, low
  input  wire logic       req_i,   // Refresh request level
  input  wire logic [4:0] delay_i, // Service delay in clocks
  output logic            done_o   // Accept pulse
);
  logic [4:0] wait_q;
  logic [1:0] cool_q;

  ////////////////////////////////////////////////////////////////////////////
  // The cool-down stops a request that is still high from being taken twice.
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      done_o <= 1'b0;
      wait_q <= 5'h00;
      cool_q <= 2'h0;
    end
    else
    begin
      done_o <= 1'b0;
      if (cool_q != 2'h0)
        cool_q <= cool_q - 2'h1;
      else if (req_i)
      begin
        if (wait_q >= delay_i)
        begin
          done_o <= 1'b1;
          wait_q <= 5'h00;
          cool_q <= 2'h2;
        end
        else
          wait_q <= wait_q + 5'h01;
      end
    end
  end
endmodule

// file: verification/drc_top_bench.sv
/*
  Self-checking bench for the DRAM control register block.
  Assumes the sequencer model and a shortened refresh tick of two clocks.
*/
`timescale 1ns/1ps
module drc_top_bench;
  import drc_pkg::*;
  localparam int unsigned TK = 2;
  logic           sys_clk;
  logic           resetn;
  drc_reg_req_t   req;
  logic [7:0]     rdata;
  logic           smm_pin;
  drc_check_evt_t evt;
  logic [5:0]     banks;
  logic           done;
  logic           rreq;
  logic [2:0]     rows;
  logic [5:0]     stag;
  drc_ctrl_t      ctrl;
  logic           serr;
  logic [4:0]     dly;
  logic [7:0]     a;
  int             fails = 0;
  int             comparisons = 0;
  int             cyc = 0;
  int             n;

  drc_top #(.TICK(TK)) dut (
    .sys_clk_i(sys_clk), .resetn_i(resetn), .reg_req_i(req),
    .reg_rdata_o(rdata), .smm_active_input_i(smm_pin), .check_evt_i(evt),
    .bank_populated_i(banks), .refresh_done_i(done),
    .refresh_req_o(rreq), .refresh_rows_o(rows),
    .refresh_stagger_o(stag), .ctrl_o(ctrl), .serr_o(serr));

  drc_seq_model seq (.clk_i(sys_clk), .rstn_i(resetn), .req_i(rreq),
    .delay_i(dly), .done_o(done));

  initial
  begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) cyc <= cyc + 1;

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [7:0] seen,
                     input logic [7:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      fails++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic close_out;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic wr(input logic [7:0] ad, input logic [7:0] d);
    @(posedge sys_clk);
    req.wr <= 1'b1;
    req.addr <= ad;
    req.wdata <= d;
    @(posedge sys_clk);
    req.wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] ad, input logic [7:0] exp);
    @(posedge sys_clk);
    req.rd <= 1'b1;
    req.addr <= ad;
    @(posedge sys_clk);
    req.rd <= 1'b0;
    #1;
    chk("register read", rdata, exp);
  endtask

  // Control outputs follow a write two edges later.
  task automatic settle;
    repeat (3) @(posedge sys_clk);
    #1;
  endtask

  task automatic wait_rise;
    int i;
    i = 0;
    while (rreq === 1'b1 && i < 1000)
    begin
      @(posedge sys_clk);
      #1;
      i++;
    end
    while (rreq !== 1'b1 && i < 1000)
    begin
      @(posedge sys_clk);
      #1;
      i++;
    end
    if (i >= 1000)
    begin
      fails++;
      $display("wrong value refresh request expected rise seen none");
      close_out();
    end
  endtask

  task automatic err(input logic s, input logic m, input logic [2:0] c,
                     input logic exp);
    @(posedge sys_clk);
    evt <= {s, m, c};
    @(posedge sys_clk);
    evt <= '0;
    #1;
    chk("system error", 8'(serr), 8'(exp));
    @(posedge sys_clk);
    #1;
    chk("system error end", 8'(serr), 8'h00);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    resetn = 1'b0;
    req = '0;
    smm_pin = 1'b0;
    evt = '0;
    banks = 6'h3F;
    dly = 5'h01;
    repeat (6) @(posedge sys_clk);
    resetn <= 1'b1;
    for (a = 8'h6A; a <= 8'h6F; a++)
      rd(a, 8'h00);
    wr(8'h70, 8'hFF);
    rd(8'h70, 8'h00);
    wr(8'h6B, 8'hFF);
    rd(8'h6B, 8'hC0);
    wr(8'h6C, 8'hFF);
    rd(8'h6C, 8'hEF);
    wr(8'h6E, 8'hFF);
    rd(8'h6E, 8'hBF);
    wr(8'h6D, 8'h7F);
    rd(8'h6D, 8'h7F);
    settle();
    chk("column first", 8'(ctrl.cbr_refresh), 8'h01);
    chk("burst write", 8'(ctrl.burst_write), 8'h01);
    chk("four bank", 8'(ctrl.four_bank), 8'h01);
    chk("interleave", 8'(ctrl.interleave), 8'h01);
    chk("line gap", 8'(ctrl.line_gap), 8'h01);
    chk("latency", 8'(ctrl.cas_latency), 8'h03);
    chk("pin address", 8'(ctrl.pin_as_address), 8'h01);
    chk("smm forced", 8'(ctrl.smm_active), 8'h01);
    chk("ecc mode", 8'(ctrl.check_ecc), 8'h01);
    chk("pair enable", 8'(ctrl.ecc_pair_en), 8'h07);
    chk("read extra", 8'(ctrl.read_extra), 8'h01);
    wr(8'h6B, 8'h00);
    for (n = 0; n < 4; n++)
    begin
      wr(8'h6C, 8'h80 | 8'(n));
      settle();
      chk("command kind", 8'(ctrl.cmd_kind), 8'(n));
      chk("depth ignored", 8'(ctrl.four_bank), 8'h00);
      chk("interleave off", 8'(ctrl.interleave), 8'h00);
      chk("line gap", 8'(ctrl.line_gap), 8'h03);
      chk("latency", 8'(ctrl.cas_latency), 8'h02);
    end
    wr(8'h6C, 8'h04);
    settle();
    chk("refresh mode", 8'(ctrl.cbr_refresh), 8'h01);
    wr(8'h6D, 8'h00);
    smm_pin <= 1'b1;
    settle();
    chk("smm pin", 8'(ctrl.smm_active), 8'h01);
    smm_pin <= 1'b0;
    settle();
    chk("smm idle", 8'(ctrl.smm_active), 8'h00);
    // Refresh spacing is taken between two rises so the start phase drops out.
    wr(8'h6A, 8'h0A);
    wait_rise();
    n = cyc;
    wait_rise();
    chk("refresh gap", 8'(cyc - n), 8'(10 * TK));
    chk("rows single", 8'(rows), 8'h01);
    wr(8'h6B, 8'h40);
    wait_rise();
    n = cyc;
    wait_rise();
    chk("burst gap", 8'(cyc - n), 8'(40 * TK));
    chk("rows burst", 8'(rows), 8'h04);
    dly <= 5'h14;
    banks <= 6'h15;
    wait_rise();
    repeat (16) @(posedge sys_clk);
    #1;
    chk("stagger", 8'(stag), 8'h15);
    dly <= 5'h01;
    wr(8'h6A, 8'h00);
    repeat (40) @(posedge sys_clk);
    n = 0;
    repeat (200)
    begin
      @(posedge sys_clk);
      #1;
      if (rreq !== 1'b0)
        n++;
    end
    chk("refresh off", 8'(n), 8'h00);
    wr(8'h6E, 8'h2F);
    err(1'b0, 1'b1, 3'h1, 1'b0);
    rd(8'h6F, 8'h00);
    wr(8'h6E, 8'hAF);
    err(1'b0, 1'b1, 3'h5, 1'b1);
    rd(8'h6F, 8'hD0);
    err(1'b1, 1'b0, 3'h2, 1'b0);
    rd(8'h6F, 8'hDA);
    wr(8'h6F, 8'h80);
    rd(8'h6F, 8'h5A);
    wr(8'h6F, 8'h70);
    rd(8'h6F, 8'h0A);
    wr(8'h6F, 8'h0F);
    rd(8'h6F, 8'h00);
    // Pair zero off: its banks are ignored, as is a code naming no bank.
    wr(8'h6E, 8'hAE);
    err(1'b0, 1'b1, 3'h1, 1'b0);
    err(1'b0, 1'b1, 3'h6, 1'b0);
    rd(8'h6F, 8'h00);
    err(1'b0, 1'b1, 3'h3, 1'b1);
    wr(8'h6E, 8'hBE);
    err(1'b1, 1'b0, 3'h2, 1'b1);
    rd(8'h6F, 8'hBA);
    close_out();
  end

  initial
  begin
    repeat (100000) @(posedge sys_clk);
    fails++;
    close_out();
  end
endmodule
